// File: mpr_consts.vh
`ifndef MPR_CONSTS_VH
`define MPR_CONSTS_VH

// Register indices; the byte address is four times the index
`define MPR_IDX_INPUT     8'h8a
`define MPR_IDX_OUTPUT    8'h8b
`define MPR_IDX_ROUTE     8'h8c

// Address decode fields of paddr
`define MPR_ADDR_W        12
`define MPR_IDX_MSB       9
`define MPR_IDX_LSB       2

// General output register
`define MPR_OUT_RESET     8'h00
`define MPR_OUT_WMASK     8'h1f

// General input register
`define MPR_IN_RESET      5'h00

// Pin routing register
`define MPR_ROUTE_RESET   32'h00001000
`define MPR_ROUTE_WMASK   32'h07777777

// Selector field positions
`define MPR_SEL_W         4
`define MPR_SEL0_LSB      0
`define MPR_SEL1_LSB      4
`define MPR_SEL2_LSB      8
`define MPR_SEL3_LSB      12
`define MPR_SEL4_LSB      16
`define MPR_SEL5_LSB      20
`define MPR_SEL6_LSB      24

// Selector codes shared by the general-purpose pins
`define MPR_CODE_INPUT    4'h0
`define MPR_CODE_OUTPUT   4'h1

// Codes that actively drive each pin, one bit per code
`define MPR_DRIVE_PIN0    16'hff3e
`define MPR_DRIVE_PIN1    16'hff2e
`define MPR_DRIVE_PIN2    16'hff3e
`define MPR_DRIVE_PIN3    16'hfffe
`define MPR_DRIVE_PIN4    16'hfb3e
`define MPR_DRIVE_PIN5    16'hf73e
`define MPR_DRIVE_PIN6    16'hfffe

`endif

// File: mpr_sync.v
`timescale 1ns/100ps
`default_nettype none

module mpr_sync #(
  parameter W = 7
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  // Two stages; only the second stage is visible outside
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule

`default_nettype wire

// File: mpr_pin_cell.v
`timescale 1ns/100ps
`default_nettype none

module mpr_pin_cell #(
  parameter [15:0] DRIVE_MASK = 16'hffff
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire [3:0]  sel,
  input  wire [15:0] src,
  output reg         pin_out,
  output reg         pin_oe
);

  // Registered mux: a selector change shows one edge later, and each pin
  // has its own flops so other pins never see a transient
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end else begin
      pin_out <= src[sel] & DRIVE_MASK[sel];
      pin_oe  <= DRIVE_MASK[sel];
    end
  end

endmodule

`default_nettype wire

// File: mpr_top.v
// Operation
// - Output register bits 4..0 hold last written values and drive output lines 4..0.
// - Output register bits 7..5 read zero; writes there are ignored.
// - Output data and all selectors reset only on the global reset.
// - Routing bits 31..28 and 27,23,19,15,11,7,3 read zero; others writable.
// - Routing resets to 0000_1000h; reset value may also come from EEPROM.
// - Pin 6: code 1 clock-run, codes 2..15 interrupt of that number, 0 reserved.
// - Pin 5: input 4, output 4, grant, interrupts, audio, LEDs, event out.
// - Pin 4: input 3, output 3, lock, interrupts, audio, ring, socket LED, event.
// - Pin 3: code 1 serial interrupt, codes 2..15 interrupt lines, 0 reserved.
// - Pin 2: input 2, output 2, request, interrupts, audio, INTC, ring, test_observe_mux.
// - Pin 1: input 1, output 1, INTB, interrupts, audio, LED one and two, event.
// - Pin 0: input 0, output 0, INTA, interrupts, audio, LED one and two, event.
// - Input-selected pins are sampled into input bits; level changes flag an event.
//
// Chosen here: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "mpr_consts.vh"

module mpr_top (
  input  wire                     pclk,
  input  wire                     presetn,
  // APB slave
  input  wire                     psel,
  input  wire                     penable,
  input  wire                     pwrite,
  input  wire [`MPR_ADDR_W-1:0]   paddr,
  input  wire [31:0]              pwdata,
  output reg  [31:0]              prdata,
  output reg                      pready,
  output reg                      pslverr,
  // Routing default from the serial configuration loader
  input  wire                     eeprom_load,
  input  wire [31:0]              eeprom_value,
  // Internal sources that may be routed to pins
  input  wire [15:0]              irq_line,
  input  wire                     clkrun,
  input  wire                     serial_interrupt,
  input  wire                     pcpci_grant,
  input  wire                     pci_lock,
  input  wire                     pcpci_request,
  input  wire                     pci_inta_n,
  input  wire                     pci_intb_n,
  input  wire                     pci_intc_n,
  input  wire                     card_audio_pwm,
  input  wire                     activity_led_one,
  input  wire                     activity_led_two,
  input  wire                     socket_led,
  input  wire                     general_event_out,
  input  wire                     ring_indicate_out,
  input  wire                     test_observe_mux,
  // Multifunction pins
  input  wire [6:0]               pin_in,
  output wire [6:0]               pin_out,
  output wire [6:0]               pin_oe,
  // Side outputs
  output reg  [4:0]               general_output,
  output reg  [4:0]               general_input_value,
  output reg  [4:0]               general_input_change
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  reg  [7:0]  general_output_values_r;
  reg  [31:0] pin_function_select_r;

  wire [3:0]  pin0_select;
  wire [3:0]  pin1_select;
  wire [3:0]  pin2_select;
  wire [3:0]  pin3_select;
  wire [3:0]  pin4_select;
  wire [3:0]  pin5_select;
  wire [3:0]  pin6_select;

  wire        out0_value;
  wire        out1_value;
  wire        out2_value;
  wire        out3_value;
  wire        out4_value;

  // Selector fields
  assign pin0_select = pin_function_select_r[`MPR_SEL0_LSB +: `MPR_SEL_W];
  assign pin1_select = pin_function_select_r[`MPR_SEL1_LSB +: `MPR_SEL_W];
  assign pin2_select = pin_function_select_r[`MPR_SEL2_LSB +: `MPR_SEL_W];
  assign pin3_select = pin_function_select_r[`MPR_SEL3_LSB +: `MPR_SEL_W];
  assign pin4_select = pin_function_select_r[`MPR_SEL4_LSB +: `MPR_SEL_W];
  assign pin5_select = pin_function_select_r[`MPR_SEL5_LSB +: `MPR_SEL_W];
  assign pin6_select = pin_function_select_r[`MPR_SEL6_LSB +: `MPR_SEL_W];

  // Output data bits
  assign out0_value = general_output_values_r[0];
  assign out1_value = general_output_values_r[1];
  assign out2_value = general_output_values_r[2];
  assign out3_value = general_output_values_r[3];
  assign out4_value = general_output_values_r[4];

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  wire        apb_setup;
  wire        apb_access;
  wire        apb_write;
  wire        addr_aligned;
  wire [7:0]  addr_index;
  wire        hit_input;
  wire        hit_output;
  wire        hit_route;
  wire        hit_any;

  assign apb_setup    = psel & ~penable;
  // Access edge is the one where pready is sampled high
  assign apb_access   = psel & penable & pready;
  assign apb_write    = apb_access & pwrite;

  // Upper bits and byte lane bits must be zero for a hit
  assign addr_aligned = (paddr[`MPR_ADDR_W-1:`MPR_IDX_MSB+1] == 2'b00) &&
                        (paddr[`MPR_IDX_LSB-1:0] == 2'b00);
  assign addr_index   = paddr[`MPR_IDX_MSB:`MPR_IDX_LSB];
  assign hit_input    = addr_aligned && (addr_index == `MPR_IDX_INPUT);
  assign hit_output   = addr_aligned && (addr_index == `MPR_IDX_OUTPUT);
  assign hit_route    = addr_aligned && (addr_index == `MPR_IDX_ROUTE);
  assign hit_any      = hit_input | hit_output | hit_route;

  ////////////////////////////////////////////////////////////////////////////
  // Read data mux

  reg  [31:0] rd_data;

  // Reserved bits are zero because the stored values are masked on write and narrower registers are zero-padded
  always @* begin
    rd_data = 32'h00000000;
    if (hit_input) begin
      rd_data = {27'h0000000, general_input_value};
    end else if (hit_output) begin
      rd_data = {24'h000000, general_output_values_r};
    end else if (hit_route) begin
      rd_data = pin_function_select_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB response

  // One wait-free access phase: pready rises in the cycle after setup.
  // Read data is latched in setup; a loader update in that one cycle is
  // not seen by the read, which is harmless for a once-set register.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready <= apb_setup;
      if (apb_setup) begin
        pslverr <= ~hit_any;
        prdata  <= rd_data;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // General output register

  // Only presetn, the global reset, clears these bits
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      general_output_values_r <= `MPR_OUT_RESET;
    end else if (apb_write && hit_output) begin
      general_output_values_r <= pwdata[7:0] & `MPR_OUT_WMASK;
    end
  end

  // Output lines follow the stored value
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      general_output <= 5'h00;
    end else begin
      general_output <= general_output_values_r[4:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin routing register

  // A loader value overrides a bus write in the same cycle, since the
  // loader delivers the board default that software expects to replace.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_function_select_r <= `MPR_ROUTE_RESET;
    end else if (eeprom_load) begin
      pin_function_select_r <= eeprom_value & `MPR_ROUTE_WMASK;
    end else if (apb_write && hit_route) begin
      pin_function_select_r <= pwdata & `MPR_ROUTE_WMASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin input sampling

  wire [6:0]  pin_in_s;
  wire [4:0]  input_pin_level;
  wire [4:0]  input_selected;

  mpr_sync #(
    .W        (7)
  ) u_pin_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (pin_in),
    .sync_out (pin_in_s)
  );

  // Inputs 3 and 4 live on pins 4 and 5
  assign input_pin_level = {pin_in_s[5], pin_in_s[4], pin_in_s[2],
                            pin_in_s[1], pin_in_s[0]};
  assign input_selected  = {pin5_select == `MPR_CODE_INPUT,
                            pin4_select == `MPR_CODE_INPUT,
                            pin2_select == `MPR_CODE_INPUT,
                            pin1_select == `MPR_CODE_INPUT,
                            pin0_select == `MPR_CODE_INPUT};

  // Input bits hold their last value while the pin serves another function
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      general_input_value  <= `MPR_IN_RESET;
      general_input_change <= 5'h00;
    end else begin
      general_input_value  <= (input_selected & input_pin_level) |
                              (~input_selected & general_input_value);
      general_input_change <= input_selected &
                              (input_pin_level ^ general_input_value);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-pin source vectors, indexed by selector code

  wire [15:0] src_pin0;
  wire [15:0] src_pin1;
  wire [15:0] src_pin2;
  wire [15:0] src_pin3;
  wire [15:0] src_pin4;
  wire [15:0] src_pin5;
  wire [15:0] src_pin6;

  // Pin 6: interrupt lines follow the code number
  assign src_pin6 = {irq_line[15:2], clkrun, 1'b0};

  // Pin 5
  assign src_pin5 = {irq_line[15], general_event_out, socket_led,
                     activity_led_one, 1'b0, irq_line[10], irq_line[9],
                     card_audio_pwm, 1'b0, 1'b0, irq_line[5], irq_line[4],
                     irq_line[3], pcpci_grant, out4_value, 1'b0};

  // Pin 4
  assign src_pin4 = {irq_line[15], general_event_out, socket_led,
                     ring_indicate_out, irq_line[11], 1'b0, irq_line[9],
                     card_audio_pwm, 1'b0, 1'b0, irq_line[5], irq_line[4],
                     irq_line[3], pci_lock, out3_value, 1'b0};

  // Pin 3: serial interrupt on code 1
  assign src_pin3 = {irq_line[15:2], serial_interrupt, 1'b0};

  // Pin 2: code 15 carries interrupt 7 here, not 15
  assign src_pin2 = {irq_line[7], general_event_out, test_observe_mux,
                     ring_indicate_out, pci_intc_n, irq_line[10], irq_line[9],
                     card_audio_pwm, 1'b0, 1'b0, irq_line[5], irq_line[4],
                     irq_line[3], pcpci_request, out2_value, 1'b0};

  // Pin 1: code 4 is reserved on this pin
  assign src_pin1 = {irq_line[15], general_event_out, activity_led_two,
                     activity_led_one, irq_line[11], irq_line[10], irq_line[9],
                     card_audio_pwm, 1'b0, 1'b0, irq_line[5], 1'b0,
                     irq_line[3], pci_intb_n, out1_value, 1'b0};

  // Pin 0
  assign src_pin0 = {irq_line[15], general_event_out, activity_led_two,
                     activity_led_one, irq_line[11], irq_line[10], irq_line[9],
                     card_audio_pwm, 1'b0, 1'b0, irq_line[5], irq_line[4],
                     irq_line[3], pci_inta_n, out0_value, 1'b0};

  ////////////////////////////////////////////////////////////////////////////
  // Pin multiplexers

  mpr_pin_cell #(
    .DRIVE_MASK (`MPR_DRIVE_PIN0)
  ) u_pin0 (
    .pclk       (pclk),
    .presetn    (presetn),
    .sel        (pin0_select),
    .src        (src_pin0),
    .pin_out    (pin_out[0]),
    .pin_oe     (pin_oe[0])
  );

  mpr_pin_cell #(
    .DRIVE_MASK (`MPR_DRIVE_PIN1)
  ) u_pin1 (
    .pclk       (pclk),
    .presetn    (presetn),
    .sel        (pin1_select),
    .src        (src_pin1),
    .pin_out    (pin_out[1]),
    .pin_oe     (pin_oe[1])
  );

  mpr_pin_cell #(
    .DRIVE_MASK (`MPR_DRIVE_PIN2)
  ) u_pin2 (
    .pclk       (pclk),
    .presetn    (presetn),
    .sel        (pin2_select),
    .src        (src_pin2),
    .pin_out    (pin_out[2]),
    .pin_oe     (pin_oe[2])
  );

  mpr_pin_cell #(
    .DRIVE_MASK (`MPR_DRIVE_PIN3)
  ) u_pin3 (
    .pclk       (pclk),
    .presetn    (presetn),
    .sel        (pin3_select),
    .src        (src_pin3),
    .pin_out    (pin_out[3]),
    .pin_oe     (pin_oe[3])
  );

  mpr_pin_cell #(
    .DRIVE_MASK (`MPR_DRIVE_PIN4)
  ) u_pin4 (
    .pclk       (pclk),
    .presetn    (presetn),
    .sel        (pin4_select),
    .src        (src_pin4),
    .pin_out    (pin_out[4]),
    .pin_oe     (pin_oe[4])
  );

  mpr_pin_cell #(
    .DRIVE_MASK (`MPR_DRIVE_PIN5)
  ) u_pin5 (
    .pclk       (pclk),
    .presetn    (presetn),
    .sel        (pin5_select),
    .src        (src_pin5),
    .pin_out    (pin_out[5]),
    .pin_oe     (pin_oe[5])
  );

  mpr_pin_cell #(
    .DRIVE_MASK (`MPR_DRIVE_PIN6)
  ) u_pin6 (
    .pclk       (pclk),
    .presetn    (presetn),
    .sel        (pin6_select),
    .src        (src_pin6),
    .pin_out    (pin_out[6]),
    .pin_oe     (pin_oe[6])
  );

endmodule

`default_nettype wire

// File: mpr_top_properties.sv
`timescale 1ns/100ps
`default_nettype none
`include "mpr_consts.vh"

module mpr_top_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        eeprom_load,
  input wire logic [31:0] eeprom_value,
  input wire logic [15:0] irq_line,
  input wire logic        serial_interrupt,
  input wire logic [6:0]  pin_out,
  input wire logic [6:0]  pin_oe,
  input wire logic [4:0]  general_output
);
  localparam logic [15:0] DM [7] = '{`MPR_DRIVE_PIN0, `MPR_DRIVE_PIN1, `MPR_DRIVE_PIN2,
    `MPR_DRIVE_PIN3, `MPR_DRIVE_PIN4, `MPR_DRIVE_PIN5, `MPR_DRIVE_PIN6};
  logic [31:0] route_sh;
  logic [4:0]  out_sh;
  logic [6:0]  drv;
  wire         wr = psel & penable & pready & pwrite;

  // Shadow registers; the loader wins over a same-cycle write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      route_sh <= `MPR_ROUTE_RESET;
      out_sh   <= 5'h00;
    end else begin
      if (eeprom_load)
        route_sh <= eeprom_value & `MPR_ROUTE_WMASK;
      else if (wr && paddr == 12'h230)
        route_sh <= pwdata & `MPR_ROUTE_WMASK;
      if (wr && paddr == 12'h22c)
        out_sh <= pwdata[4:0];
    end
  end

  // Which pins the shadow selectors should drive
  always_comb begin
    for (int i = 0; i < 7; i++)
      drv[i] = DM[i][route_sh[4*i +: 4]];
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_one: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not one cycle after setup");
  a_err_unaligned: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("unaligned access not refused");
  a_outreg_read: assert property (psel && !penable && !pwrite && paddr == 12'h22c
    |=> prdata == {27'h0, $past(out_sh)}) else $error("output register read wrong");
  a_route_read: assert property (psel && !penable && !pwrite && paddr == 12'h230
    |=> prdata == $past(route_sh) && !pslverr) else $error("routing read wrong");
  a_gpo_follow: assert property (general_output == $past(out_sh))
    else $error("general output lags or wrong");
  // Pin cells still hold reset values at the first edge after release
  a_drive_enable: assert property ($past(presetn) |-> pin_oe == $past(drv))
    else $error("pin enable does not follow selectors");
  a_undriven_low: assert property ((pin_out & ~pin_oe) == 7'h00)
    else $error("undriven pin shows a value");
  a_pin3_serial: assert property ($past(presetn) && $past(route_sh[15:12]) == 4'h1
    |-> pin_out[3] == $past(serial_interrupt)) else $error("pin 3 serial wrong");
  a_pin6_irq: assert property ($past(presetn) && $past(route_sh[27:24]) > 4'h1
    |-> pin_out[6] == $past(irq_line[route_sh[27:24]])) else $error("pin 6 irq wrong");
endmodule

bind mpr_top mpr_top_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .eeprom_load, .eeprom_value, .irq_line,
  .serial_interrupt, .pin_out, .pin_oe, .general_output);
`default_nettype wire

// File: mpr_board.sv
`timescale 1ns/100ps
`default_nettype none

module mpr_board (
  input  wire logic [6:0] pin_out,
  input  wire logic [6:0] pin_oe,
  input  wire logic [6:0] ext_level,
  output logic      [6:0] pin_in
);
  // Board pulls set the level of a released pin; a driving device overrides it
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule
`default_nettype wire

// File: mpr_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module mpr_top_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, eeprom_load, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, eeprom_value, rd;
  logic [15:0] irq_line;
  logic [14:0] src;
  logic [6:0]  ext_level, pin_in, pin_out, pin_oe;
  logic [4:0]  general_output, general_input_value, general_input_change;
  int          errors, checks_done;

  mpr_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .eeprom_load, .eeprom_value, .irq_line, .clkrun(src[0]),
    .serial_interrupt(src[1]), .pcpci_grant(src[2]), .pci_lock(src[3]),
    .pcpci_request(src[4]), .pci_inta_n(src[5]), .pci_intb_n(src[6]), .pci_intc_n(src[7]),
    .card_audio_pwm(src[8]), .activity_led_one(src[9]), .activity_led_two(src[10]),
    .socket_led(src[11]), .general_event_out(src[12]), .ring_indicate_out(src[13]),
    .test_observe_mux(src[14]), .pin_in, .pin_out, .pin_oe, .general_output,
    .general_input_value, .general_input_change);
  mpr_board u_board (.pin_out, .pin_oe, .ext_level, .pin_in);

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; held until pready is sampled, then an idle cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      $display("MISMATCH t=%0t no pready", $time);
      test_done();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Waits, bounded, for an input change pulse; one edge passes first so a
  // pulse that ends at the caller's edge is not taken for a new one
  task automatic wait_change;
    int n;
    n = 0;
    @(posedge pclk);
    while (general_input_change === 5'h00 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    check(32'(n < 20), 32'h1, "no input event");
  endtask

  // Pins driven for a code copied into all seven selectors
  function automatic logic [6:0] exp_oe(input int c);
    case (c)
      0: return 7'h00;
      4: return 7'h7d;
      6, 7: return 7'h48;
      default: return 7'h7f;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // Watchdog so that a hang still reaches the verdict
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    $display("MISMATCH t=%0t run timeout", $time);
    test_done();
  end

  initial begin
    {presetn, psel, penable, pwrite, eeprom_load} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    eeprom_value = 32'h0;
    irq_line = 16'h0000;
    src = 15'h0000;
    ext_level = 7'h00;
    errors = 0;
    checks_done = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h230, 32'h0);
    check(rd, 32'h00001000, "route reset");
    apb(1'b0, 12'h22c, 32'h0);
    check(rd, 32'h0, "out reset");
    apb(1'b1, 12'h22c, 32'hffffffff);
    apb(1'b0, 12'h22c, 32'h0);
    check(rd, 32'h1f, "out upper bits");
    check(32'(general_output), 32'h1f, "general output");
    apb(1'b1, 12'h230, 32'hffffffff);
    apb(1'b0, 12'h230, 32'h0);
    check(rd, 32'h07777777, "route mask");
    // Unmapped and unaligned accesses are refused
    apb(1'b0, 12'h234, 32'h0);
    check(rd, 32'h0, "unmapped read");
    check(32'(er), 32'h1, "unmapped error");
    apb(1'b1, 12'h22e, 32'h0);
    check(32'(er), 32'h1, "unaligned error");
    apb(1'b0, 12'h22c, 32'h0);
    check(rd, 32'h1f, "unaligned write");
    // Every writable code on every pin, sources high then low
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, 12'h230, 32'h01111111 * c);
      irq_line <= 16'h0001 << c;
      src <= 15'h7fff;
      repeat (3) @(posedge pclk);
      check(32'(pin_oe), 32'(exp_oe(c)), "pin enable");
      check(32'(pin_out), 32'(exp_oe(c)), "pin high");
      irq_line <= ~(16'h0001 << c);
      src <= 15'h0000;
      apb(1'b1, 12'h22c, 32'h0);
      repeat (3) @(posedge pclk);
      check(32'(pin_out), 32'h0, "pin low");
      apb(1'b1, 12'h22c, 32'h1f);
    end
    // Inputs sampled with change events
    apb(1'b1, 12'h230, 32'h0);
    ext_level <= 7'h7f;
    wait_change();
    check(32'({general_input_change, general_input_value}), 32'h3ff, "inputs high");
    ext_level <= 7'h6f;
    wait_change();
    check(32'({general_input_change, general_input_value}), 32'h117, "pin 4 low");
    apb(1'b0, 12'h228, 32'h0);
    check(rd, 32'h17, "input register");
    // Loader overrides the routing
    eeprom_value <= 32'hffffffff;
    eeprom_load <= 1'b1;
    @(posedge pclk);
    eeprom_load <= 1'b0;
    apb(1'b0, 12'h230, 32'h0);
    check(rd, 32'h07777777, "loaded route");
    // A second reset restores defaults
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h22c, 32'h0);
    check(rd, 32'h0, "out after reset");
    apb(1'b0, 12'h230, 32'h0);
    check(rd, 32'h00001000, "route after reset");
    check(32'(pin_oe), 32'h08, "pin 3 after reset");
    test_done();
  end
endmodule
`default_nettype wire
